// ---- amd_pkg.sv ----
// Purpose: constants for the addressing mode decoder
// Assumes: 8-bit core, 16-bit address space
// Notes:   opcode column layout follows the usual 8-bit core map
package amd_pkg;

  // prefix byte values
  localparam logic [7:0] AMD_Y_SWAP_PREFIX     = 8'h90;
  localparam logic [7:0] AMD_Y_INDIRECT_PREFIX = 8'h91;
  localparam logic [7:0] AMD_INDIRECT_PREFIX   = 8'h92;

  // instruction set size
  localparam int AMD_NUM_INSTR  = 63;
  localparam int AMD_NUM_GROUPS = 13;
  localparam int AMD_MAX_LEN    = 4;

  // reset values
  localparam logic [15:0] AMD_PC_RESET = 16'h0000;

  // addressing modes
  typedef enum logic [4:0] {
    AMD_M_INH,
    AMD_M_IMM,
    AMD_M_DIR_S,
    AMD_M_DIR_L,
    AMD_M_IDX_0,
    AMD_M_IDX_S,
    AMD_M_IDX_L,
    AMD_M_IND_S,
    AMD_M_IND_L,
    AMD_M_IIX_S,
    AMD_M_IIX_L,
    AMD_M_REL_D,
    AMD_M_REL_I,
    AMD_M_BIT_D,
    AMD_M_BIT_I,
    AMD_M_BTR_D,
    AMD_M_BTR_I,
    AMD_M_ILLEGAL
  } amd_mode_e;

  // fetch sequencer states
  typedef enum logic [3:0] {
    AMD_S_OPC,
    AMD_S_B1,
    AMD_S_B2,
    AMD_S_PTR_HI,
    AMD_S_PTR_LO,
    AMD_S_REL_OFS,
    AMD_S_BTR_OFS,
    AMD_S_DONE
  } amd_state_e;

endpackage : amd_pkg

// ---- amd_decoder.sv ----
// Purpose: instruction fetch and effective address resolution
// Assumes: memory answers a read in the same cycle (comb rdata)
// Notes:   one byte read per cycle; ALU and flags live elsewhere
`timescale 1ns/100ps
`default_nettype none

module amd_decoder
  import amd_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // program/data memory read port
  output logic      [15:0] mem_addr_o,
  output logic             mem_rd_o,
  input  wire logic [7:0]  mem_rdata_i,
  // index registers from the core
  input  wire logic [7:0]  x_reg_i,
  input  wire logic [7:0]  y_reg_i,
  // core handshake
  input  wire logic        start_i,
  input  wire logic        branch_taken_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             illegal_o,
  // decode results
  output logic      [7:0]  opcode_o,
  output logic      [4:0]  mode_o,
  output logic             use_y_o,
  output logic      [2:0]  length_o,
  output logic             operand_is_imm_o,
  output logic      [7:0]  operand_o,
  output logic      [15:0] ea_o,
  output logic      [15:0] next_pc_o,
  output logic      [15:0] branch_target_o
);

  amd_state_e  state_q, state_d;
  amd_mode_e   mode_q;
  logic [15:0] pc_q;
  logic [7:0]  opc_q;
  logic [7:0]  prefix_q;
  logic [7:0]  b1_q;
  logic [7:0]  ptr_hi_q;
  logic [2:0]  len_q;
  logic        done_q;
  logic        illegal_q;
  logic [15:0] ea_q;
  logic        use_y_q;

  // prefix recognition
  wire is_pfx_y   = (mem_rdata_i == AMD_Y_SWAP_PREFIX);
  wire is_pfx_ind = (mem_rdata_i == AMD_INDIRECT_PREFIX);
  wire is_pfx_iy  = (mem_rdata_i == AMD_Y_INDIRECT_PREFIX);
  wire is_pfx     = is_pfx_y | is_pfx_ind | is_pfx_iy;

  wire pfx_y   = (prefix_q == AMD_Y_SWAP_PREFIX);
  wire pfx_ind = (prefix_q == AMD_INDIRECT_PREFIX);
  wire pfx_iy  = (prefix_q == AMD_Y_INDIRECT_PREFIX);

  // opcode fields in the row/column map
  wire [3:0] row = mem_rdata_i[7:4];
  wire [3:0] col = mem_rdata_i[3:0];

  // base mode from opcode row (and column D in row A), X-based forms
  amd_mode_e base_mode;
  always_comb begin
    base_mode = AMD_M_INH;
    if (row == 4'h0) begin
      base_mode = AMD_M_BTR_D;
    end else if (row == 4'h1) begin
      base_mode = AMD_M_BIT_D;
    end else if (row == 4'h2) begin
      base_mode = AMD_M_REL_D;
    end else if (row == 4'h3) begin
      base_mode = AMD_M_DIR_S;
    end else if (row == 4'h4 || row == 4'h5 || row == 4'h8 || row == 4'h9) begin
      base_mode = AMD_M_INH;
    end else if (row == 4'h6) begin
      base_mode = AMD_M_IDX_S;
    end else if (row == 4'h7) begin
      base_mode = AMD_M_IDX_0;
    end else if (row == 4'hA) begin
      base_mode = (col == 4'hD) ? AMD_M_REL_D : AMD_M_IMM;
    end else if (row == 4'hB) begin
      base_mode = AMD_M_DIR_S;
    end else if (row == 4'hC) begin
      base_mode = AMD_M_DIR_L;
    end else if (row == 4'hD) begin
      base_mode = AMD_M_IDX_L;
    end else if (row == 4'hE) begin
      base_mode = AMD_M_IDX_S;
    end else begin
      base_mode = AMD_M_IDX_0;
    end
  end

  // read-modify-write rows, short forms only
  wire rmw_row = (row == 4'h3) || (row == 4'h6) || (row == 4'h7) || (row <= 4'h1);

  // prefix conversion of the base mode
  amd_mode_e eff_mode;
  logic      eff_illegal;
  always_comb begin
    eff_mode    = base_mode;
    eff_illegal = 1'b0;
    if (pfx_ind) begin
      if (base_mode == AMD_M_DIR_S) begin
        eff_mode = rmw_row ? AMD_M_IND_S : AMD_M_IND_S;
      end else if (base_mode == AMD_M_DIR_L) begin
        eff_mode = AMD_M_IND_L;
      end else if (base_mode == AMD_M_BIT_D) begin
        eff_mode = AMD_M_BIT_I;
      end else if (base_mode == AMD_M_BTR_D) begin
        eff_mode = AMD_M_BTR_I;
      end else if (base_mode == AMD_M_REL_D) begin
        eff_mode = AMD_M_REL_I;
      end else if (base_mode == AMD_M_IDX_S) begin
        eff_mode = AMD_M_IIX_S;
      end else if (base_mode == AMD_M_IDX_L) begin
        eff_mode = AMD_M_IIX_L;
      end else begin
        eff_illegal = 1'b1;
      end
    end else if (pfx_iy) begin
      if (base_mode == AMD_M_IDX_S) begin
        eff_mode = AMD_M_IIX_S;
      end else if (base_mode == AMD_M_IDX_L) begin
        eff_mode = AMD_M_IIX_L;
      end else begin
        eff_illegal = 1'b1;
      end
    end else if (pfx_y) begin
      if (base_mode == AMD_M_BIT_D || base_mode == AMD_M_BTR_D || base_mode == AMD_M_REL_D) begin
        eff_illegal = 1'b1;
      end
    end
    if (rmw_row && (eff_mode == AMD_M_DIR_L || eff_mode == AMD_M_IDX_L)) begin
      eff_illegal = 1'b1;
    end
  end

  wire eff_y = pfx_y | pfx_iy;

  // index selection
  wire [7:0]  idx     = eff_y ? y_reg_i : x_reg_i;
  wire [15:0] idx16   = {8'h00, idx};
  wire [15:0] pc_inc  = pc_q + 16'h0001;

  // address sums, no wrap at 8 bits
  wire [15:0] sum_short = idx16 + {8'h00, mem_rdata_i};
  wire [15:0] sum_ptr_s = idx16 + {8'h00, mem_rdata_i};
  wire [15:0] sum_long  = idx16 + {b1_q, mem_rdata_i};
  wire [15:0] sum_ptr_l = idx16 + {ptr_hi_q, mem_rdata_i};
  wire [15:0] rel_base  = pc_inc;
  wire [15:0] rel_tgt   = rel_base + {{8{mem_rdata_i[7]}}, mem_rdata_i};
  // pc already past the instruction when the offset comes from memory
  wire [15:0] rel_tgt_i = pc_q + {{8{mem_rdata_i[7]}}, mem_rdata_i};

  // next state and memory address
  always_comb begin
    state_d    = state_q;
    mem_addr_o = pc_q;
    mem_rd_o   = 1'b0;
    case (state_q)
      AMD_S_OPC: begin
        mem_rd_o = start_i | (prefix_q != 8'h00);
        if (mem_rd_o && !is_pfx) begin
          if (eff_mode == AMD_M_INH || eff_mode == AMD_M_IDX_0) begin
            state_d = AMD_S_DONE;
          end else begin
            state_d = AMD_S_B1;
          end
        end
      end
      AMD_S_B1: begin
        mem_rd_o = 1'b1;
        if (mode_q == AMD_M_DIR_L || mode_q == AMD_M_IDX_L) begin
          state_d = AMD_S_B2;
        end else if (mode_q == AMD_M_IND_L || mode_q == AMD_M_IIX_L) begin
          state_d = AMD_S_PTR_HI;
        end else if (mode_q == AMD_M_IND_S || mode_q == AMD_M_IIX_S || mode_q == AMD_M_BIT_I
                     || mode_q == AMD_M_BTR_I || mode_q == AMD_M_REL_I) begin
          state_d = AMD_S_PTR_LO;
        end else if (mode_q == AMD_M_BTR_D) begin
          state_d = AMD_S_BTR_OFS;
        end else begin
          state_d = AMD_S_DONE;
        end
      end
      AMD_S_B2: begin
        mem_rd_o = 1'b1;
        state_d  = AMD_S_DONE;
      end
      AMD_S_PTR_HI: begin
        mem_rd_o   = 1'b1;
        mem_addr_o = {8'h00, b1_q};
        state_d    = AMD_S_PTR_LO;
      end
      AMD_S_PTR_LO: begin
        mem_rd_o   = 1'b1;
        mem_addr_o = (mode_q == AMD_M_IND_L || mode_q == AMD_M_IIX_L) ?
                     ({8'h00, b1_q} + 16'h0001) : {8'h00, b1_q};
        state_d    = (mode_q == AMD_M_BTR_I) ? AMD_S_BTR_OFS : AMD_S_DONE;
      end
      AMD_S_BTR_OFS: begin
        mem_rd_o = 1'b1;
        state_d  = AMD_S_DONE;
      end
      default: begin
        state_d = AMD_S_OPC;
      end
    endcase
  end

  // sequential state
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_q <= AMD_S_OPC;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pc_q      <= AMD_PC_RESET;
      prefix_q  <= 8'h00;
      opc_q     <= 8'h00;
      mode_q    <= AMD_M_INH;
      b1_q      <= 8'h00;
      ptr_hi_q  <= 8'h00;
      len_q     <= 3'd0;
      ea_q      <= 16'h0000;
      done_q    <= 1'b0;
      illegal_q <= 1'b0;
      use_y_q   <= 1'b0;
    end else begin
      done_q <= (state_q == AMD_S_DONE);
      if (state_q == AMD_S_DONE) begin
        prefix_q <= 8'h00;
        if (branch_taken_i && (mode_q == AMD_M_REL_D || mode_q == AMD_M_REL_I
                               || mode_q == AMD_M_BTR_D || mode_q == AMD_M_BTR_I)) begin
          pc_q <= ea_q;
        end
      end
      if (mem_rd_o && state_q != AMD_S_PTR_HI && state_q != AMD_S_PTR_LO) begin
        pc_q  <= pc_inc;
        len_q <= (state_q == AMD_S_OPC && prefix_q == 8'h00) ? 3'd1 : len_q + 3'd1;
      end
      case (state_q)
        AMD_S_OPC: begin
          if (mem_rd_o) begin
            if (is_pfx) begin
              prefix_q <= mem_rdata_i;
            end else begin
              opc_q     <= mem_rdata_i;
              mode_q    <= eff_illegal ? AMD_M_ILLEGAL : eff_mode;
              illegal_q <= eff_illegal;
              use_y_q   <= eff_y;
              ea_q      <= idx16;
            end
          end
        end
        AMD_S_B1: begin
          b1_q <= mem_rdata_i;
          if (mode_q == AMD_M_IDX_S) begin
            ea_q <= sum_short;
          end else if (mode_q == AMD_M_REL_D) begin
            ea_q <= rel_tgt;
          end else begin
            ea_q <= {8'h00, mem_rdata_i};
          end
        end
        AMD_S_B2: begin
          ea_q <= (mode_q == AMD_M_IDX_L) ? sum_long : {b1_q, mem_rdata_i};
        end
        AMD_S_PTR_HI: begin
          ptr_hi_q <= mem_rdata_i;
        end
        AMD_S_PTR_LO: begin
          if (mode_q == AMD_M_IND_L) begin
            ea_q <= {ptr_hi_q, mem_rdata_i};
          end else if (mode_q == AMD_M_IIX_L) begin
            ea_q <= sum_ptr_l;
          end else if (mode_q == AMD_M_IIX_S) begin
            ea_q <= sum_ptr_s;
          end else if (mode_q == AMD_M_REL_I) begin
            ea_q <= rel_tgt_i;
          end else begin
            ea_q <= {8'h00, mem_rdata_i};
          end
        end
        AMD_S_BTR_OFS: begin
          if (mode_q == AMD_M_BTR_I) begin
            b1_q <= ea_q[7:0];
          end
          ea_q <= rel_tgt;
        end
        default: begin
        end
      endcase
    end
  end

  // outputs
  assign busy_o           = (state_q != AMD_S_OPC) || (prefix_q != 8'h00);
  assign done_o           = done_q;
  assign illegal_o        = illegal_q;
  assign opcode_o         = opc_q;
  assign mode_o           = mode_q;
  assign use_y_o          = use_y_q;
  assign length_o         = len_q;
  assign operand_is_imm_o = (mode_q == AMD_M_IMM);
  assign operand_o        = b1_q;
  assign ea_o             = ea_q;
  assign next_pc_o        = pc_q;
  assign branch_target_o  = ea_q;

endmodule // amd_decoder
`default_nettype wire

// ---- amd_decoder_chk.sv ----
// Purpose: port-level checks for the addressing mode decoder
// Assumes: one clock domain, synchronous active-high reset
// Notes:   results are judged in the cycle of the done pulse
`timescale 1ns/100ps
`default_nettype none
module amd_decoder_chk
  import amd_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  // watched signals
  input wire logic        branch_taken_i,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic [4:0]  mode_o,
  input wire logic [2:0]  length_o,
  input wire logic        operand_is_imm_o,
  input wire logic [7:0]  operand_o,
  input wire logic [15:0] ea_o,
  input wire logic [15:0] next_pc_o,
  input wire logic [15:0] branch_target_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire rel_w = done_o && (mode_o == AMD_M_REL_D || mode_o == AMD_M_REL_I);

  property p_done_pulse; done_o |=> !done_o; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_answer; $rose(busy_o) |-> ##[1:7] done_o; endproperty
  a_answer: assert property (p_answer) else $error("no done within seven cycles");
  property p_len; done_o |-> length_o >= 3'h1 && length_o <= 3'h4; endproperty
  a_len: assert property (p_len) else $error("length outside one to four");
  property p_inh; done_o && mode_o == AMD_M_INH |-> length_o <= 3'h2 && !operand_is_imm_o; endproperty
  a_inh: assert property (p_inh) else $error("inherent length wrong");
  property p_imm; done_o && mode_o == AMD_M_IMM |-> operand_is_imm_o && length_o >= 3'h2; endproperty
  a_imm: assert property (p_imm) else $error("immediate operand not flagged");
  property p_dir_s; done_o && mode_o == AMD_M_DIR_S |-> ea_o == {8'h00, operand_o}; endproperty
  a_dir_s: assert property (p_dir_s) else $error("short direct address wrong");
  property p_dir_l; done_o && mode_o == AMD_M_DIR_L |-> ea_o[15:8] == operand_o && length_o >= 3'h3; endproperty
  a_dir_l: assert property (p_dir_l) else $error("long direct high byte wrong");
  property p_idx_0; done_o && mode_o == AMD_M_IDX_0 |-> ea_o[15:8] == 8'h00; endproperty
  a_idx_0: assert property (p_idx_0) else $error("no-offset index left page zero");
  property p_short_sum; done_o && (mode_o == AMD_M_IDX_S || mode_o == AMD_M_IIX_S) |-> ea_o <= 16'h01FE;
  endproperty
  a_short_sum: assert property (p_short_sum) else $error("short indexed sum above 1FE");
  property p_rel_d;
    done_o && mode_o == AMD_M_REL_D && !$past(branch_taken_i) |->
      branch_target_o == next_pc_o + {{8{operand_o[7]}}, operand_o};
  endproperty
  a_rel_d: assert property (p_rel_d) else $error("relative target wrong");
  property p_rel_ea;
    rel_w && !$past(branch_taken_i) |-> (branch_target_o - next_pc_o + 16'h0080) <= 16'h00FF;
  endproperty
  a_rel_ea: assert property (p_rel_ea) else $error("branch target beyond signed byte reach");
endmodule // amd_decoder_chk

bind amd_decoder amd_decoder_chk u_chk (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .branch_taken_i(branch_taken_i), .busy_o(busy_o),
  .done_o(done_o), .mode_o(mode_o), .length_o(length_o), .operand_is_imm_o(operand_is_imm_o),
  .operand_o(operand_o), .ea_o(ea_o), .next_pc_o(next_pc_o), .branch_target_o(branch_target_o)
);
`default_nettype wire

// ---- amd_decoder_bench.sv ----
// Purpose: random and corner decode runs against a byte memory
// Assumes: memory answers in the same cycle as the read
// Notes:   modes 0..17 follow the enum order of amd_mode_e
`timescale 1ns/100ps
`default_nettype none
module amd_decoder_bench;
  import amd_pkg::*;
  // stimulus
  logic        ref_clk_i = 1'b0;
  logic        rst_i, start_i, branch_taken_i;
  logic [7:0]  x_reg_i, y_reg_i, mem_rdata_i;
  // results
  logic [15:0] mem_addr_o, ea_o, next_pc_o, branch_target_o;
  logic        mem_rd_o, busy_o, done_o, illegal_o, use_y_o, operand_is_imm_o;
  logic [7:0]  opcode_o, operand_o;
  logic [4:0]  mode_o;
  logic [2:0]  length_o;
  // bench state
  logic [7:0]  mem [0:65535];
  logic [31:0] seed = 32'h00015981;
  logic [15:0] pc = 16'h0000;
  int          miscompares = 0;
  int          comparisons = 0;
  int          it;
  localparam logic [3:0] ROW_T [18] = '{4'h4, 4'hA, 4'hB, 4'hC, 4'hF, 4'hE, 4'hD, 4'hB, 4'hC, 4'hE, 4'hD, 4'h2, 4'h2,
                                        4'h1, 4'h1, 4'h0, 4'h0, 4'hB};
  localparam int         NB_T [18]  = '{0, 1, 1, 2, 0, 1, 2, 1, 1, 1, 1, 1, 1, 1, 1, 2, 2, 1};

  always #25 ref_clk_i = ~ref_clk_i;
  assign mem_rdata_i = mem[mem_addr_o];

  amd_decoder DUT (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
    .mem_rdata_i(mem_rdata_i), .x_reg_i(x_reg_i), .y_reg_i(y_reg_i), .start_i(start_i),
    .branch_taken_i(branch_taken_i), .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o),
    .opcode_o(opcode_o), .mode_o(mode_o), .use_y_o(use_y_o), .length_o(length_o),
    .operand_is_imm_o(operand_is_imm_o), .operand_o(operand_o), .ea_o(ea_o),
    .next_pc_o(next_pc_o), .branch_target_o(branch_target_o)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // pointer must not sit on the bytes of the instruction
  function automatic logic ov(input logic [7:0] p);
    logic [15:0] a;
    a = {8'h00, p} - pc;
    return (a < 16'h0004) || (a == 16'hFFFF) || (p == 8'hFF);
  endfunction

  function automatic logic [15:0] f_ea(input int k, input logic [7:0] b1, b2, idx, d0, d1,
                                       input logic [15:0] nxt);
    case (k)
      2: return {8'h00, b1};
      3: return {b1, b2};
      4: return {8'h00, idx};
      5: return {8'h00, b1} + {8'h00, idx};
      6: return {b1, b2} + {8'h00, idx};
      7: return {8'h00, d0};
      8: return {d0, d1};
      9: return {8'h00, d0} + {8'h00, idx};
      10: return {d0, d1} + {8'h00, idx};
      11: return nxt + {{8{b1[7]}}, b1};
      12: return nxt + {{8{d0[7]}}, d0};
      13: return {8'h00, b1};
      14: return {8'h00, d0};
      15, 16: return nxt + {{8{b2[7]}}, b2};
      default: return 16'h0000;
    endcase
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic run(input int k, input logic corner);
    logic [31:0] r, q;
    logic [7:0]  b1, b2, d0, d1, idx, opc, pre;
    logic [15:0] ea, a, nxt;
    int          pl, n;
    logic        tk, ind;
    @(negedge ref_clk_i);
    r = corner ? 32'hFFFFFFFF : rnd();
    q = rnd();
    {b2, b1, y_reg_i, x_reg_i} = r;
    d0 = corner ? 8'hFF : q[23:16];
    d1 = q[31:24];
    opc = {ROW_T[k], q[3:0]};
    if (k == 0 && q[4]) opc[7:4] = 4'h8;
    if (k == 1 && q[3:0] == 4'hD) opc[3:0] = 4'hC;
    if (q[5] && (k == 2 || k == 7)) opc[7:4] = 4'h3;
    if (q[5] && (k == 5 || k == 9)) opc[7:4] = 4'h6;
    if (q[5] && k == 4) opc[7:4] = 4'h7;
    ind = k inside {7, 8, 9, 10, 12, 14, 16};
    pre = ind ? AMD_INDIRECT_PREFIX : AMD_Y_SWAP_PREFIX;
    if ((k == 9 || k == 10) && q[6]) pre = AMD_Y_INDIRECT_PREFIX;
    // y indirect prefix before a direct opcode is refused
    if (k == 17) pre = AMD_Y_INDIRECT_PREFIX;
    pl = (ind || k == 17 || (q[7] && k inside {0, 1, 4, 5, 6})) ? 1 : 0;
    idx = (pl == 1 && pre != AMD_INDIRECT_PREFIX) ? y_reg_i : x_reg_i;
    while (ind && ov(b1)) b1 = b1 + 8'h07;
    if (ind) begin
      mem[{8'h00, b1}] = d0;
      mem[{8'h00, b1} + 16'h0001] = d1;
    end
    a = pc;
    if (pl == 1) begin
      mem[a] = pre;
      a++;
    end
    mem[a] = opc;
    mem[a + 16'h0001] = b1;
    mem[a + 16'h0002] = b2;
    nxt = pc + 16'(pl + 1 + NB_T[k]);
    ea = f_ea(k, b1, b2, idx, d0, d1, nxt);
    tk = (k inside {11, 12, 15, 16}) & q[8];
    branch_taken_i = tk;
    start_i = 1'b1;
    @(negedge ref_clk_i) start_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 10) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk({15'h0000, done_o}, 16'h0001);
    chk({11'h000, mode_o}, 16'(k));
    chk({13'h0000, length_o}, nxt - pc);
    chk({8'h00, opcode_o}, {8'h00, opc});
    chk({15'h0000, operand_is_imm_o}, 16'(k == 1));
    if (k != 0 && k != 4) chk({8'h00, operand_o}, {8'h00, (k == 16) ? d0 : b1});
    if (k > 1 && k != 17) chk(ea_o, ea);
    if (!tk) chk(next_pc_o, nxt);
    chk({15'h0000, illegal_o}, 16'(k == 17));
    chk({15'h0000, use_y_o}, 16'(pl == 1 && pre != AMD_INDIRECT_PREFIX));
    pc = tk ? ea : nxt;
  endtask

  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    rst_i = 1'b1;
    start_i = 1'b0;
    branch_taken_i = 1'b0;
    x_reg_i = 8'h00;
    y_reg_i = 8'h00;
    repeat (4) @(posedge ref_clk_i);
    @(negedge ref_clk_i) rst_i = 1'b0;
    // first pass walks every mode with all-ones corner values
    for (it = 0; it < 400; it++) run(it < 18 ? it : int'(rnd() % 18), it < 18);
    print_verdict();
  end

  // about 400 runs of under 12 cycles each; far more than enough
  initial begin
    #1000000;
    miscompares++;
    print_verdict();
  end
endmodule // amd_decoder_bench
`default_nettype wire
